/* hw/scf_core.sv */
`timescale 1ns/10ps
`default_nettype none
module scf_core
	import scf_pkg::*;
#(
	parameter logic [15:0] PART_ID = 16'h5a3c // Arbitrary identity value.
) (
	input  wire logic                  core_clk,               // Core clock.
	input  wire logic                  rst,                    // Synchronous reset.
	input  wire logic                  ref_tick,               // One pulse per reference cycle.
	input  wire logic [TOC_W-1:0]      fastlock_timeout_count, // Fastlock timeout.
	input  wire logic [GAIN_W-1:0]     fastlock_pump_gain,     // Fastlock pump gain.
	input  wire logic                  fastlock_force,         // Hold fastlock on.
	input  wire logic [GAIN_W-1:0]     steady_pump_gain,       // Steady pump gain.
	input  wire logic [BLEED_W-1:0]    pump_bleed_setting,     // Bleed setting.
	input  wire logic                  pump_polarity,          // Polarity, 1 negative.
	input  wire logic [DIV_W-1:0]      out_div_code,           // Shared output divider code.
	input  wire logic [PWR_W-1:0]      out_a_power_level,      // Output A power.
	input  wire logic [PWR_W-1:0]      out_b_power_level,      // Output B power.
	input  wire logic                  out_a_shutdown,         // Output A shutdown.
	input  wire logic                  out_b_shutdown,         // Output B shutdown.
	input  wire logic                  ref_doubler_enable,     // Reference doubler.
	input  wire logic [R_W-1:0]        ref_div_code,           // Reference divider code.
	input  wire logic [DEN_W-1:0]      frac_denominator,       // Fraction denominator.
	input  wire logic [2:0]            modulator_order,        // Modulator order.
	input  wire logic [CORE_W-1:0]     start_core,             // Calibration start core.
	input  wire logic                  readback_source_select, // 1 reads identity.
	input  wire logic [15:0]           reg_contents,           // Register data for readback.
	input  wire scf_freq_word_s        freq_word,              // Frequency word.
	input  wire logic                  freq_word_write,        // Frequency word write strobe.
	input  wire logic                  cal_above,              // Oscillator below target, step up.
	input  wire logic                  cal_locked,             // Oscillator at target.
	output scf_pump_s                  pump,                   // Applied pump setting.
	output logic [BLEED_W-1:0]         bleed,                  // Applied bleed.
	output logic                       fastlock_active,        // Fastlock engaged.
	output logic                       fastlock_cfg_invalid,   // Force with zero timeout.
	output logic [DIV_W+1:0]           out_a_ratio,            // Output A ratio.
	output logic [PWR_W-1:0]           out_a_power,            // Output A power applied.
	output logic                       out_a_enabled,          // Output A powered.
	output logic [DIV_W+1:0]           out_b_ratio,            // Output B ratio.
	output logic [PWR_W-1:0]           out_b_power,            // Output B power applied.
	output logic                       out_b_enabled,          // Output B powered.
	output logic                       out_cfg_invalid,        // Bad output code.
	output logic                       ref_doubled,            // Doubler on.
	output logic [R_W:0]               ref_div_ratio,          // Reference ratio.
	output logic [N_W-1:0]             feedback_div,           // Applied feedback divider.
	output logic [DEN_W-1:0]           frac_num,               // Applied numerator.
	output logic [DEN_W-1:0]           frac_den,               // Applied denominator.
	output logic [1:0]                 modulator_applied,      // Applied order.
	output logic                       modulator_invalid,      // Reserved order code.
	output scf_dither_e                dither_applied,         // Applied dither.
	output logic [15:0]                readback_data,          // Readback word.
	output logic                       cal_busy,               // Calibration running.
	output logic                       cal_done,               // Calibration end pulse.
	output logic                       cal_success,            // Last calibration locked.
	output logic [CORE_W-1:0]          cal_core,               // Current core.
	output logic [BAND_W-1:0]          cal_band                // Current band.
);

	typedef enum logic [1:0] {scf_cal_idle, scf_cal_step, scf_cal_end} scf_cal_state_e;

	// Doubles a timeout code into reference cycles.
	function automatic logic [TOC_W:0] scf_toc_cycles(input logic [TOC_W-1:0] code);
		scf_toc_cycles = {code, 1'b0};
	endfunction : scf_toc_cycles
	logic [TOC_W:0]  fl_count;
	logic [TOC_W:0]  next_fl_count;
	logic            fl_run;
	logic            next_fl_run;
	scf_pump_s       next_pump;
	logic            next_active;
	// Fastlock countdown in reference cycles, restarted by each frequency write.
	always_comb begin
		next_fl_count = fl_count;
		next_fl_run   = fl_run;
		if (fastlock_timeout_count == '0) begin
			next_fl_run   = 1'b0;
			next_fl_count = '0;
		end else if (freq_word_write) begin
			next_fl_count = scf_toc_cycles(fastlock_timeout_count);
			next_fl_run   = 1'b1;
		end else if (fl_run && ref_tick) begin
			next_fl_count = fl_count - 13'h0001;
			if (fl_count == 13'h0001) begin
				next_fl_run = 1'b0;
			end
		end
		next_active = (fastlock_timeout_count != '0) && (fastlock_force || next_fl_run);
		next_pump.polarity = pump_polarity;
		if (next_active) begin
			next_pump.gain = fastlock_pump_gain;
		end else begin
			next_pump.gain = steady_pump_gain;
		end
		next_pump.hi_z = (next_pump.gain == '0);
	end

	// Fastlock and pump registers; polarity resets to negative.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fl_count             <= '0;
			fl_run               <= 1'b0;
			fastlock_active      <= 1'b0;
			pump                 <= '{gain: '0, hi_z: 1'b1, polarity: POL_NEGATIVE};
			bleed                <= '0;
			fastlock_cfg_invalid <= 1'b0;
		end else begin
			fl_count             <= next_fl_count;
			fl_run               <= next_fl_run;
			fastlock_active      <= next_active;
			pump                 <= next_pump;
			bleed                <= pump_bleed_setting;
			fastlock_cfg_invalid <= fastlock_force && (fastlock_timeout_count == '0);
		end
	end

	logic inv_a;
	logic inv_b;
	// Both outputs share the divider code.
	scf_out_div u_out_a (
		.core_clk    (core_clk),
		.rst         (rst),
		.div_code    (out_div_code),
		.power_code  (out_a_power_level),
		.shutdown    (out_a_shutdown),
		.div_ratio   (out_a_ratio),
		.power_level (out_a_power),
		.enabled     (out_a_enabled),
		.cfg_invalid (inv_a)
	);
	scf_out_div u_out_b (
		.core_clk    (core_clk),
		.rst         (rst),
		.div_code    (out_div_code),
		.power_code  (out_b_power_level),
		.shutdown    (out_b_shutdown),
		.div_ratio   (out_b_ratio),
		.power_level (out_b_power),
		.enabled     (out_b_enabled),
		.cfg_invalid (inv_b)
	);
	assign out_cfg_invalid = inv_a | inv_b;
	logic [R_W:0]     next_ref_ratio;
	logic [DEN_W-1:0] next_num;
	logic [1:0]       next_order;
	logic             next_order_bad;
	logic [15:0]      next_readback;
	// Reference path, frequency word and readback decode.
	always_comb begin
		if (ref_div_code == '0) begin
			next_ref_ratio = R_DIV_ZERO_VAL;
		end else begin
			next_ref_ratio = {1'b0, ref_div_code};
		end
		next_num = {freq_word.num_hi, freq_word.num_lo};
		next_order_bad = (modulator_order > {1'b0, ORDER_MAX});
		next_order = next_order_bad ? modulator_applied : modulator_order[1:0];
		next_readback = readback_source_select ? PART_ID : reg_contents;
	end

	// Frequency word fields are applied on their write strobe.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_doubled       <= 1'b0;
			ref_div_ratio     <= 9'h001;
			feedback_div      <= '0;
			frac_num          <= '0;
			frac_den          <= '0;
			modulator_applied <= '0;
			modulator_invalid <= 1'b0;
			dither_applied    <= scf_dither_weak;
			readback_data     <= '0;
		end else begin
			ref_doubled       <= ref_doubler_enable;
			ref_div_ratio     <= next_ref_ratio;
			frac_den          <= frac_denominator;
			modulator_applied <= next_order;
			modulator_invalid <= next_order_bad;
			readback_data     <= next_readback;
			if (freq_word_write) begin
				feedback_div   <= freq_word.feedback_div;
				frac_num       <= next_num;
				dither_applied <= scf_dither_e'(freq_word.dither_mode);
			end
		end
	end
	scf_cal_state_e   cal_state;
	scf_cal_state_e   next_cal_state;
	logic [CORE_W-1:0] next_core;
	logic [BAND_W-1:0] next_band;
	logic              next_success;
	// Calibration walks bands, then higher cores, until lock or exhaustion.
	always_comb begin
		next_cal_state = cal_state;
		next_core      = cal_core;
		next_band      = cal_band;
		next_success   = cal_success;
		case (cal_state)
			scf_cal_idle: begin
				if (freq_word_write && !freq_word.skip_calibration) begin
					next_cal_state = scf_cal_step;
					next_core      = start_core;
					next_band      = BAND_START;
					next_success   = 1'b0;
				end
			end
			scf_cal_step: begin
				if (cal_locked) begin
					next_success   = 1'b1;
					next_cal_state = scf_cal_end;
				end else if ((cal_above && cal_band == BAND_TOP)
					|| (!cal_above && cal_band == BAND_BOTTOM)) begin
					if (cal_core != CORE_TOP) begin
						next_core = cal_core + 2'h1;
						next_band = BAND_START;
					end else begin
						next_cal_state = scf_cal_end;
					end
				end else if (cal_above) begin
					next_band = cal_band + 8'h01;
				end else begin
					next_band = cal_band - 8'h01;
				end
			end
			default: begin
				next_cal_state = scf_cal_idle;
			end
		endcase
	end
	// Calibration registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cal_state   <= scf_cal_idle;
			cal_core    <= '0;
			cal_band    <= BAND_START;
			cal_success <= 1'b0;
		end else begin
			cal_state   <= next_cal_state;
			cal_core    <= next_core;
			cal_band    <= next_band;
			cal_success <= next_success;
		end
	end
	assign cal_busy = (cal_state == scf_cal_step);
	assign cal_done = (cal_state == scf_cal_end);

	sequence s_cal_write;
		freq_word_write && !freq_word.skip_calibration && cal_state == scf_cal_idle;
	endsequence
	chk_cal_start : assert property (@(posedge core_clk) disable iff (rst)
		s_cal_write |=> cal_busy && cal_core == $past(start_core)) else $error("no cal start");
	chk_cal_skip : assert property (@(posedge core_clk) disable iff (rst)
		(cal_state == scf_cal_idle && !(freq_word_write && !freq_word.skip_calibration))
		|=> !cal_busy) else $error("cal started without request");
	chk_fl_disabled : assert property (@(posedge core_clk) disable iff (rst)
		(fastlock_timeout_count == '0) |=> !fastlock_active) else $error("fastlock on at zero");
	chk_fl_gain : assert property (@(posedge core_clk) disable iff (rst)
		fastlock_active |-> pump.gain == $past(fastlock_pump_gain)) else $error("fl gain");
	chk_steady_gain : assert property (@(posedge core_clk) disable iff (rst)
		!fastlock_active |-> pump.gain == $past(steady_pump_gain)) else $error("steady gain");
	chk_force_hold : assert property (@(posedge core_clk) disable iff (rst)
		(fastlock_force && fastlock_timeout_count != '0) |=> fastlock_active)
		else $error("force not held");
	chk_ref_zero : assert property (@(posedge core_clk) disable iff (rst)
		(ref_div_code == '0) |=> ref_div_ratio == R_DIV_ZERO_VAL) else $error("ref div 0");
	chk_readback_id : assert property (@(posedge core_clk) disable iff (rst)
		readback_source_select |=> readback_data == PART_ID) else $error("readback id");
	chk_polarity : assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> pump.polarity == $past(pump_polarity)) else $error("polarity");
	chk_band_limit : assert property (@(posedge core_clk) disable iff (rst)
		(cal_busy && !cal_locked && cal_core == CORE_TOP && (cal_above ? cal_band == BAND_TOP
		: cal_band == BAND_BOTTOM)) |=> cal_done ##1 !cal_busy) else $error("cal did not end");

endmodule : scf_core
`default_nettype wire

/* hw/scf_out_div.sv */
`timescale 1ns/10ps
`default_nettype none
// Decodes one output's divider, power and shutdown setting into registered drive.
module scf_out_div
	import scf_pkg::*;
(
	input  wire logic             core_clk,    // Core clock.
	input  wire logic             rst,         // Synchronous reset.
	input  wire logic [DIV_W-1:0] div_code,    // Divider code.
	input  wire logic [PWR_W-1:0] power_code,  // Power level code.
	input  wire logic             shutdown,    // Output shutdown request.
	output logic      [DIV_W+1:0] div_ratio,   // Effective division ratio.
	output logic      [PWR_W-1:0] power_level, // Applied power level.
	output logic                  enabled,     // Output is powered.
	output logic                  cfg_invalid  // Divider or power code not allowed.
);

	logic [DIV_W+1:0] next_div_ratio;
	logic [PWR_W-1:0] next_power_level;
	logic             next_enabled;
	logic             next_cfg_invalid;

	// Ratio is 2*(k+1); bad codes hold the last good value and flag.
	always_comb begin
		next_div_ratio   = div_ratio;
		next_power_level = power_level;
		next_enabled     = !shutdown;
		next_cfg_invalid = 1'b0;
		if (div_code <= DIV_CODE_MAX) begin
			next_div_ratio = {1'b0, div_code, 1'b0} + 7'h02;
		end else begin
			next_cfg_invalid = 1'b1;
		end
		if (power_code <= PWR_CODE_MAX) begin
			next_power_level = power_code;
		end else begin
			next_cfg_invalid = 1'b1;
		end
	end

	// Registers.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_ratio   <= 7'h02;
			power_level <= '0;
			enabled     <= 1'b0;
			cfg_invalid <= 1'b0;
		end else begin
			div_ratio   <= next_div_ratio;
			power_level <= next_power_level;
			enabled     <= next_enabled;
			cfg_invalid <= next_cfg_invalid;
		end
	end

	chk_shutdown_off : assert property (@(posedge core_clk) disable iff (rst)
		shutdown |=> !enabled) else $error("shutdown did not disable output");

	chk_div_ratio : assert property (@(posedge core_clk) disable iff (rst)
		(div_code <= DIV_CODE_MAX) |=> div_ratio == {1'b0, $past(div_code), 1'b0} + 7'h02)
		else $error("divider ratio wrong");

	chk_power_hold : assert property (@(posedge core_clk) disable iff (rst)
		(power_code > PWR_CODE_MAX) |=> cfg_invalid && $stable(power_level))
		else $error("reserved power code applied");

endmodule : scf_out_div
`default_nettype wire

/* hw/scf_pkg.sv */
package scf_pkg;

	// Field widths.
	localparam int TOC_W   = 12;
	localparam int GAIN_W  = 5;
	localparam int BLEED_W = 6;
	localparam int DIV_W   = 5;
	localparam int PWR_W   = 6;
	localparam int DEN_W   = 22;
	localparam int NUM_HI_W = 10;
	localparam int NUM_LO_W = 12;
	localparam int N_W     = 12;
	localparam int R_W     = 8;
	localparam int BAND_W  = 8;
	localparam int CORE_W  = 2;

	// Limits and codes.
	localparam logic [DIV_W-1:0]  DIV_CODE_MAX   = 5'h12;
	localparam logic [PWR_W-1:0]  PWR_CODE_MAX   = 6'h2f;
	localparam logic [2:0]        ORDER_MAX      = 3'h3;
	localparam logic [BAND_W-1:0] BAND_TOP       = 8'hff;
	localparam logic [BAND_W-1:0] BAND_BOTTOM    = 8'h00;
	localparam logic [BAND_W-1:0] BAND_START     = 8'h80;
	localparam logic [CORE_W-1:0] CORE_TOP       = 2'h3;
	localparam logic [R_W:0]      R_DIV_ZERO_VAL = 9'h100;
	localparam logic              POL_NEGATIVE   = 1'b1;

	// Dither modes.
	typedef enum logic [1:0] {
		scf_dither_weak,
		scf_dither_medium,
		scf_dither_strong,
		scf_dither_off
	} scf_dither_e;

	// Frequency word written by the host, with its strobe.
	typedef struct packed {
		logic [N_W-1:0]      feedback_div;
		logic [NUM_HI_W-1:0] num_hi;
		logic [NUM_LO_W-1:0] num_lo;
		logic [1:0]          dither_mode;
		logic                skip_calibration;
	} scf_freq_word_s;

	// Pump settings applied to the loop.
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic              hi_z;
		logic              polarity;
	} scf_pump_s;

endpackage : scf_pkg

/* test/scf_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Behavioural oscillator and reference source beside the synthesizer core.
module scf_osc_model #(
	parameter int TICK_DIV = 4 // Core cycles per reference cycle.
) (
	input  wire logic       core_clk,    // Core clock.
	input  wire logic       rst,         // Synchronous reset.
	input  wire logic       cal_busy,    // Calibration running.
	input  wire logic [1:0] cal_core,    // Core under trial.
	input  wire logic [7:0] cal_band,    // Band under trial.
	input  wire logic [1:0] target_core, // Core that can reach the target.
	input  wire logic [7:0] target_band, // Band that reaches the target.
	output logic            ref_tick,    // One pulse per reference cycle.
	output logic            cal_above,   // Oscillator below target, step up.
	output logic            cal_locked   // Oscillator on target.
);
	logic [7:0] tick_cnt;
	logic       idle_flip;

	// Reference divider and an idle pattern so stale levels never look meaningful.
	always_ff @(posedge core_clk) begin
		if (rst || tick_cnt == 8'(TICK_DIV - 1)) begin
			tick_cnt <= 8'h00;
		end else begin
			tick_cnt <= tick_cnt + 8'h01;
		end
		idle_flip <= rst ? 1'b0 : ~idle_flip;
	end

	// The band and core comparison steers the search toward the target.
	assign ref_tick   = (tick_cnt == 8'h00) && !rst;
	assign cal_locked = cal_busy && cal_core == target_core && cal_band == target_band;
	assign cal_above  = cal_busy ? ((cal_core < target_core) ||
		(cal_core == target_core && cal_band < target_band)) : idle_flip;
endmodule : scf_osc_model
`default_nettype wire

/* test/tb_synth_config_fields.sv */
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the synthesizer configuration core.
module tb_synth_config_fields
	import scf_pkg::*;
;
	typedef struct {int sel; logic [31:0] val;} scf_note_s;
	logic core_clk, rst, ref_tick, fastlock_force, pump_polarity, out_a_shutdown, out_b_shutdown;
	logic ref_doubler_enable, readback_source_select, freq_word_write, cal_above, cal_locked;
	logic [11:0] fastlock_timeout_count;
	logic [4:0] fastlock_pump_gain, steady_pump_gain, out_div_code;
	logic [5:0] pump_bleed_setting, out_a_power_level, out_b_power_level, bleed;
	logic [7:0] ref_div_code, tgt_band, cal_band;
	logic [21:0] frac_denominator, frac_num, frac_den;
	logic [2:0] modulator_order;
	logic [1:0] start_core, tgt_core, modulator_applied, cal_core;
	logic [15:0] reg_contents, readback_data;
	scf_freq_word_s freq_word;
	scf_pump_s pump;
	scf_dither_e dither_applied;
	logic fastlock_active, fastlock_cfg_invalid, out_a_enabled, out_b_enabled, out_cfg_invalid;
	logic ref_doubled, modulator_invalid, cal_busy, cal_done, cal_success;
	logic [6:0] out_a_ratio, out_b_ratio;
	logic [8:0] ref_div_ratio;
	logic [11:0] feedback_div;
	logic [5:0] out_a_power, out_b_power;
	int seed = 73;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	scf_note_s notes[$];
	scf_note_s cur;

	// Identity value is arbitrary.
	scf_core #(.PART_ID(16'h1234)) dut (.core_clk, .rst, .ref_tick, .fastlock_timeout_count,
		.fastlock_pump_gain, .fastlock_force, .steady_pump_gain, .pump_bleed_setting,
		.pump_polarity, .out_div_code, .out_a_power_level, .out_b_power_level, .out_a_shutdown,
		.out_b_shutdown, .ref_doubler_enable, .ref_div_code, .frac_denominator, .modulator_order,
		.start_core, .readback_source_select, .reg_contents, .freq_word, .freq_word_write,
		.cal_above, .cal_locked, .pump, .bleed, .fastlock_active, .fastlock_cfg_invalid,
		.out_a_ratio, .out_a_power, .out_a_enabled, .out_b_ratio, .out_b_power, .out_b_enabled,
		.out_cfg_invalid, .ref_doubled, .ref_div_ratio, .feedback_div, .frac_num, .frac_den,
		.modulator_applied, .modulator_invalid, .dither_applied, .readback_data, .cal_busy,
		.cal_done, .cal_success, .cal_core, .cal_band);

	scf_osc_model #(.TICK_DIV(4)) osc (.core_clk, .rst, .cal_busy, .cal_core, .cal_band,
		.target_core(tgt_core), .target_band(tgt_band), .ref_tick, .cal_above, .cal_locked);

	// Selects one observed output group by number.
	function automatic logic [31:0] peek(input int sel);
		case (sel)
			0: peek = {27'h0, pump.gain};
			1: peek = {31'h0, pump.hi_z};
			2: peek = {31'h0, pump.polarity};
			3: peek = {31'h0, fastlock_active};
			4: peek = {25'h0, out_a_ratio};
			5: peek = {25'h0, out_b_ratio};
			6: peek = {26'h0, out_a_power};
			7: peek = {26'h0, out_b_power};
			8: peek = {30'h0, out_a_enabled, out_b_enabled};
			9: peek = {31'h0, out_cfg_invalid};
			10: peek = {22'h0, ref_doubled, ref_div_ratio};
			11: peek = {10'h0, frac_num};
			12: peek = {20'h0, feedback_div};
			13: peek = {29'h0, modulator_invalid, modulator_applied};
			14: peek = {30'h0, dither_applied};
			15: peek = {16'h0, readback_data};
			16: peek = {29'h0, cal_success, cal_core};
			17: peek = {24'h0, cal_band};
			18: peek = {30'h0, fastlock_cfg_invalid, cal_busy};
			19: peek = {26'h0, bleed};
			default: peek = {10'h0, frac_den};
		endcase
	endfunction : peek

	task automatic note(input int sel, input logic [31:0] val);
		notes.push_back('{sel, val});
	endtask : note

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic fwrite(input logic skip);
		freq_word.skip_calibration = skip;
		freq_word_write = 1'b1;
		cyc(1);
		freq_word_write = 1'b0;
	endtask : fwrite

	// Runs one calibration and notes where it should finish.
	task automatic cal_run(input logic [1:0] sc, input logic [1:0] tc, input logic [7:0] tb,
		input logic ok);
		int w;
		start_core = sc;
		tgt_core = tc;
		tgt_band = tb;
		fwrite(1'b0);
		note(18, 32'h1);
		for (w = 0; w < 1200 && cal_done !== 1'b1; w++) cyc(1);
		note(16, {29'h0, ok, ok ? tc : 2'h3});
		if (ok) note(17, {24'h0, tb});
		cyc(2);
		note(18, 32'h0);
	endtask : cal_run

	task automatic finish_test;
		$display("Checks made %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Compares each noted expectation once the outputs have settled.
	always begin
		@(negedge core_clk);
		#2;
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			tests_run++;
			if (peek(cur.sel) !== cur.val) begin
				fail_count++;
				$display("FAIL t=%0t group %0d got %h want %h", $time, cur.sel, peek(cur.sel), cur.val);
			end
		end
	end

	// Cuts a hang short.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		logic [7:0] rc [5];
		int pa, pb;
		rc = '{8'h00, 8'h01, 8'h02, 8'hff, 8'h5b};
		{rst, fastlock_force, out_a_shutdown, out_b_shutdown, ref_doubler_enable} = 5'b10000;
		{readback_source_select, freq_word_write, pump_polarity} = 3'b001;
		{fastlock_timeout_count, fastlock_pump_gain, steady_pump_gain} = '0;
		{pump_bleed_setting, out_div_code, out_a_power_level, out_b_power_level} = '0;
		{frac_denominator, modulator_order, start_core, reg_contents} = '0;
		ref_div_code = 8'h01;
		{tgt_core, tgt_band} = '0;
		freq_word = '0;
		freq_word.feedback_div = 12'd14;
		cyc(2);
		note(0, 32'h0);
		note(2, 32'h1);
		note(4, 32'h2);
		note(8, 32'h0);
		note(17, 32'h80);
		rst = 1'b0;
		$display("Test reset done");
		for (int k = 0; k <= 18; k++) begin
			out_div_code = 5'(k);
			cyc(2);
			note(4, 2 * (k + 1));
			note(5, 2 * (k + 1));
		end
		out_div_code = 5'h14;
		cyc(2);
		note(9, 32'h1);
		note(4, 32'd38);
		out_div_code = 5'h00;
		for (int i = 0; i < 8; i++) begin
			pa = $unsigned($random(seed)) % 48;
			pb = $unsigned($random(seed)) % 48;
			out_a_power_level = 6'(pa);
			out_b_power_level = 6'(pb);
			cyc(2);
			note(6, pa);
			note(7, pb);
			note(9, 32'h0);
		end
		out_b_power_level = 6'h30;
		cyc(2);
		note(9, 32'h1);
		note(7, pb);
		out_b_power_level = 6'h2f;
		for (int i = 0; i < 4; i++) begin
			{out_a_shutdown, out_b_shutdown} = 2'(i);
			cyc(2);
			note(8, ~i & 3);
		end
		for (int i = 0; i < 5; i++) begin
			ref_div_code = rc[i];
			ref_doubler_enable = rc[i][0];
			cyc(2);
			note(10, {22'h0, rc[i][0], (rc[i] == 8'h00) ? 9'h100 : {1'b0, rc[i]}});
		end
		for (int o = 0; o < 4; o++) begin
			modulator_order = 3'(o);
			frac_denominator = (o == 0) ? 22'h0 : 22'h1 | 22'($random(seed));
			cyc(2);
			note(13, o);
			note(20, {10'h0, frac_denominator});
		end
		modulator_order = 3'h5;
		cyc(2);
		note(13, 32'h7);
		for (int i = 0; i < 2; i++) begin
			reg_contents = 16'($random(seed));
			readback_source_select = i[0];
			cyc(2);
			note(15, i ? 32'h1234 : {16'h0, reg_contents});
		end
		$display("Test static fields done");
		for (int d = 0; d < 4; d++) begin
			freq_word.num_hi = 10'($random(seed));
			freq_word.num_lo = 12'($random(seed));
			freq_word.dither_mode = 2'(d);
			freq_word.feedback_div = 12'(14 + ($unsigned($random(seed)) % 4000));
			fwrite(1'b1);
			note(18, 32'h0);
			note(11, {10'h0, freq_word.num_hi, freq_word.num_lo});
			note(12, {20'h0, freq_word.feedback_div});
			note(14, d);
			cyc(1);
		end
		$display("Test frequency word done");
		cal_run(2'h1, 2'h1, 8'h90, 1'b1);
		cal_run(2'h0, 2'h1, 8'h70, 1'b1);
		cal_run(2'h2, 2'h0, 8'h10, 1'b0);
		$display("Test calibration done");
		{fastlock_timeout_count, fastlock_pump_gain, steady_pump_gain} = {12'd3, 5'd0, 5'd5};
		pump_bleed_setting = 6'd2;
		fwrite(1'b1);
		cyc(1);
		note(3, 32'h1);
		note(1, 32'h1);
		cyc(17);
		note(3, 32'h1);
		cyc(12);
		note(3, 32'h0);
		note(0, 32'h5);
		note(19, 32'h2);
		{fastlock_timeout_count, fastlock_pump_gain, steady_pump_gain} = {12'd1, 5'd31, 5'd0};
		pump_bleed_setting = 6'd0;
		fwrite(1'b1);
		cyc(1);
		note(0, 32'd31);
		cyc(14);
		note(3, 32'h0);
		note(1, 32'h1);
		{fastlock_force, fastlock_timeout_count} = {1'b1, 12'd2};
		fwrite(1'b1);
		cyc(40);
		note(3, 32'h1);
		fastlock_timeout_count = 12'd0;
		cyc(2);
		note(3, 32'h0);
		note(18, 32'h2);
		fastlock_force = 1'b0;
		fwrite(1'b1);
		cyc(1);
		note(3, 32'h0);
		pump_polarity = 1'b0;
		cyc(2);
		note(2, 32'h0);
		pump_polarity = 1'b1;
		cyc(2);
		note(2, 32'h1);
		cyc(2);
		$display("Test fastlock and pump done");
		finish_test();
	end
endmodule : tb_synth_config_fields
`default_nettype wire
